// >>> core/utq_top.sv
// Purpose: Double-buffered serial transmitter and receiver with
//          AXI4-Lite registers and three interrupt outputs.
// Assumes: Inputs synchronous to CORE_CLK; 10 MHz clock.
// Notes:   Baud divisor register sets clocks per bit minus one.
//
// Added by the designer: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "utq_defs.svh"
module utq_top
	import utq_pkg::*;
(
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// AXI4-Lite write address
	input wire logic [4:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	// AXI4-Lite write data
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	// AXI4-Lite write response
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	// AXI4-Lite read address
	input wire logic [4:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	// AXI4-Lite read data
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	// Serial line
	input wire logic SERIAL_RECEIVE_PIN,
	output logic SERIAL_TRANSMIT_PIN,
	// Interrupts
	output logic RX_COMPLETE_IRQ,
	output logic RX_ERROR_IRQ,
	output logic TX_COMPLETE_IRQ
);
	logic [7:0] serial_mode_register_r;
	logic [15:0] baud_r;
	logic [7:0] transmit_buffer_r;
	logic [7:0] receive_buffer_r;
	logic [2:0] rx_error_status_register_r;
	logic tx_buffer_full_flag_r;
	logic tx_shift_busy_flag_r;
	logic rx_unread_r;
	logic aw_hold_r;
	logic w_hold_r;
	logic [4:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;
	logic wr_go;
	logic rd_go;
	logic rd_err;
	logic rd_rxbuf;
	logic tx_write;
	utq_tx_e tx_state_r;
	logic [15:0] tx_cnt_r;
	logic [3:0] tx_bit_r;
	logic [8:0] tx_shift_r;
	logic [3:0] tx_nbits;
	logic [7:0] tx_char;
	logic tx_stop_left_r;
	logic unit_en;
	logic tx_en;
	logic rx_en;
	logic route;
	logic rx_done;
	logic [7:0] rx_data;
	logic rx_par;
	logic rx_frm;
	logic rx_ovr;
	logic rx_any_err;

	function automatic logic hit(input logic [4:0] a, input logic [4:0] o);
		hit = (a[4:2] == o[4:2]);
	endfunction

	assign unit_en = serial_mode_register_r[`UTQ_MODE_UNIT_EN];
	assign tx_en = unit_en && serial_mode_register_r[`UTQ_MODE_TX_EN];
	assign rx_en = unit_en && serial_mode_register_r[`UTQ_MODE_RX_EN];
	assign route = serial_mode_register_r[`UTQ_MODE_ROUTE];

	// ****************************************
	// AXI4-Lite slave
	// ****************************************
	assign wr_go = aw_hold_r && w_hold_r && !S_AXI_BVALID;
	assign rd_go = S_AXI_ARVALID && S_AXI_ARREADY;
	assign rd_err = rd_go && hit(S_AXI_ARADDR, `UTQ_OFS_ERR);
	assign rd_rxbuf = rd_go && hit(S_AXI_ARADDR, `UTQ_OFS_RXBUF);
	assign tx_write = wr_go && wstrb_r[0]
		&& hit(awaddr_r, `UTQ_OFS_TXBUF);

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_hold_r <= 1'b0;
			w_hold_r <= 1'b0;
			awaddr_r <= 5'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			S_AXI_AWREADY <= 1'b0;
			S_AXI_WREADY <= 1'b0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_BRESP <= 2'h0;
		end else begin
			S_AXI_AWREADY <= !aw_hold_r && !S_AXI_AWREADY
				&& S_AXI_AWVALID;
			S_AXI_WREADY <= !w_hold_r && !S_AXI_WREADY && S_AXI_WVALID;
			if (S_AXI_AWVALID && S_AXI_AWREADY) begin
				aw_hold_r <= 1'b1;
				awaddr_r <= S_AXI_AWADDR;
			end
			if (S_AXI_WVALID && S_AXI_WREADY) begin
				w_hold_r <= 1'b1;
				wdata_r <= S_AXI_WDATA;
				wstrb_r <= S_AXI_WSTRB;
			end
			if (wr_go) begin
				aw_hold_r <= 1'b0;
				w_hold_r <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				S_AXI_BRESP <= (awaddr_r > `UTQ_OFS_BAUD) ? 2'h2 : 2'h0;
			end else if (S_AXI_BREADY) begin
				S_AXI_BVALID <= 1'b0;
			end
		end
	end

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			S_AXI_ARREADY <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h00000000;
			S_AXI_RRESP <= 2'h0;
		end else begin
			S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID
				&& S_AXI_ARVALID;
			if (rd_go) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RRESP <= 2'h0;
				S_AXI_RDATA <= 32'h00000000;
				case (S_AXI_ARADDR[4:2])
					3'h0: S_AXI_RDATA[7:0] <= serial_mode_register_r;
					3'h1: S_AXI_RDATA[1:0] <= {tx_buffer_full_flag_r,
						tx_shift_busy_flag_r};
					3'h2: S_AXI_RDATA[7:0] <= transmit_buffer_r;
					3'h3: S_AXI_RDATA[7:0] <= receive_buffer_r;
					3'h4: S_AXI_RDATA[2:0] <= rx_error_status_register_r;
					3'h5: S_AXI_RDATA[15:0] <= baud_r;
					default: S_AXI_RRESP <= 2'h2;
				endcase
			end else if (S_AXI_RREADY) begin
				S_AXI_RVALID <= 1'b0;
			end
		end
	end

	// ****************************************
	// Control registers
	// ****************************************
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			serial_mode_register_r <= `UTQ_MODE_RESET;
			baud_r <= `UTQ_BAUD_RESET;
		end else if (wr_go && wstrb_r[0]) begin
			if (hit(awaddr_r, `UTQ_OFS_MODE)) begin
				serial_mode_register_r <= wdata_r[7:0];
			end
			if (hit(awaddr_r, `UTQ_OFS_BAUD)) begin
				baud_r <= {wstrb_r[1] ? wdata_r[15:8] : baud_r[15:8],
					wdata_r[7:0]};
			end
		end
	end

	// ****************************************
	// Transmitter
	// ****************************************
	assign tx_nbits = (serial_mode_register_r[`UTQ_MODE_CHAR8] ? 4'h8 : 4'h7)
		+ {3'h0, serial_mode_register_r[4:3] != `UTQ_PAR_NONE};
	assign tx_char = transmit_buffer_r
		& (serial_mode_register_r[`UTQ_MODE_CHAR8] ? 8'hFF : 8'h7F);

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			tx_state_r <= UTQ_TX_IDLE;
			tx_cnt_r <= 16'h0000;
			tx_bit_r <= 4'h0;
			tx_shift_r <= 9'h000;
			tx_stop_left_r <= 1'b0;
			transmit_buffer_r <= 8'h00;
			tx_buffer_full_flag_r <= 1'b0;
			tx_shift_busy_flag_r <= 1'b0;
			SERIAL_TRANSMIT_PIN <= 1'b1;
			TX_COMPLETE_IRQ <= 1'b0;
		end else begin
			TX_COMPLETE_IRQ <= 1'b0;
			if (!tx_en) begin
				tx_state_r <= UTQ_TX_IDLE;
				tx_buffer_full_flag_r <= 1'b0;
				tx_shift_busy_flag_r <= 1'b0;
				SERIAL_TRANSMIT_PIN <= 1'b1;
			end else begin
				if (tx_write) begin
					transmit_buffer_r <= wdata_r[7:0];
					tx_buffer_full_flag_r <= 1'b1;
				end
				case (tx_state_r)
					UTQ_TX_IDLE: begin
						if (tx_buffer_full_flag_r) begin
							tx_state_r <= UTQ_TX_SHIFT;
							tx_buffer_full_flag_r <= tx_write;
							tx_shift_busy_flag_r <= 1'b1;
							SERIAL_TRANSMIT_PIN <= 1'b0;
							tx_shift_r <= {1'b0, tx_char};
							case (serial_mode_register_r[4:3])
								`UTQ_PAR_EVEN: tx_shift_r[tx_nbits - 4'h1]
									<= ^tx_char;
								`UTQ_PAR_ODD: tx_shift_r[tx_nbits - 4'h1]
									<= ~(^tx_char);
								default: ;
							endcase
							tx_cnt_r <= baud_r;
							tx_bit_r <= 4'h0;
						end
					end
					UTQ_TX_SHIFT: begin
						if (tx_cnt_r == 16'h0000) begin
							tx_cnt_r <= baud_r;
							if (tx_bit_r == tx_nbits) begin
								tx_state_r <= UTQ_TX_STOP;
								SERIAL_TRANSMIT_PIN <= 1'b1;
								tx_stop_left_r <=
									serial_mode_register_r[`UTQ_MODE_STOP2];
								if (!serial_mode_register_r[`UTQ_MODE_STOP2])
								begin
									TX_COMPLETE_IRQ <= 1'b1;
									tx_shift_busy_flag_r <=
										tx_buffer_full_flag_r;
								end
							end else begin
								SERIAL_TRANSMIT_PIN <= tx_shift_r[tx_bit_r];
								tx_bit_r <= tx_bit_r + 4'h1;
							end
						end else begin
							tx_cnt_r <= tx_cnt_r - 16'h0001;
						end
					end
					UTQ_TX_STOP: begin
						if (tx_cnt_r == 16'h0000) begin
							tx_cnt_r <= baud_r;
							if (tx_stop_left_r) begin
								tx_stop_left_r <= 1'b0;
								TX_COMPLETE_IRQ <= 1'b1;
								tx_shift_busy_flag_r <= tx_buffer_full_flag_r;
							end else begin
								tx_state_r <= UTQ_TX_IDLE;
							end
						end else begin
							tx_cnt_r <= tx_cnt_r - 16'h0001;
						end
					end
					default: tx_state_r <= UTQ_TX_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// Receiver and error reporting
	// ****************************************
	utq_receiver u_rx (
		.clk(CORE_CLK),
		.rst_n(RST_N),
		.enable_i(rx_en),
		.parity_i(serial_mode_register_r[4:3]),
		.char8_i(serial_mode_register_r[`UTQ_MODE_CHAR8]),
		.div_i(baud_r),
		.rxd_i(SERIAL_RECEIVE_PIN),
		.done_o(rx_done),
		.data_o(rx_data),
		.par_err_o(rx_par),
		.frm_err_o(rx_frm)
	);

	assign rx_ovr = rx_unread_r && !rd_rxbuf;
	assign rx_any_err = rx_par || rx_frm || rx_ovr;

	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			receive_buffer_r <= 8'h00;
			rx_unread_r <= 1'b0;
			rx_error_status_register_r <= 3'h0;
			RX_COMPLETE_IRQ <= 1'b0;
			RX_ERROR_IRQ <= 1'b0;
		end else begin
			RX_COMPLETE_IRQ <= 1'b0;
			RX_ERROR_IRQ <= 1'b0;
			if (rd_rxbuf) begin
				rx_unread_r <= 1'b0;
			end
			if (rd_err) begin
				rx_error_status_register_r <= 3'h0;
			end
			if (rx_done && rx_en) begin
				if (!rx_ovr) begin
					receive_buffer_r <= rx_data;
					rx_unread_r <= 1'b1;
				end
				rx_error_status_register_r <=
					(rd_err ? 3'h0 : rx_error_status_register_r)
					| {rx_par, rx_frm, rx_ovr};
				if (rx_any_err && !route) begin
					RX_ERROR_IRQ <= 1'b1;
				end else begin
					RX_COMPLETE_IRQ <= 1'b1;
				end
			end
		end
	end
endmodule

// >>> core/utq_defs.svh
// Purpose: Register offsets, field positions and timing counts for the
//          serial transmit queue and receiver.
// Assumes: 10 MHz CORE_CLK, AXI4-Lite register access.
// Notes:   Definitions only.
`ifndef UTQ_DEFS_SVH
`define UTQ_DEFS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define UTQ_OFS_MODE 5'h00
`define UTQ_OFS_TXFLAG 5'h04
`define UTQ_OFS_TXBUF 5'h08
`define UTQ_OFS_RXBUF 5'h0C
`define UTQ_OFS_ERR 5'h10
`define UTQ_OFS_BAUD 5'h14

// ****************************************
// Mode register fields
// ****************************************
`define UTQ_MODE_UNIT_EN 7
`define UTQ_MODE_TX_EN 6
`define UTQ_MODE_RX_EN 5
`define UTQ_MODE_PAR_HI 4
`define UTQ_MODE_PAR_LO 3
`define UTQ_MODE_CHAR8 2
`define UTQ_MODE_STOP2 1
`define UTQ_MODE_ROUTE 0
`define UTQ_MODE_RESET 8'h01

// ****************************************
// Flag and error fields
// ****************************************
`define UTQ_FLAG_BUF_FULL 1
`define UTQ_FLAG_SHIFT_BUSY 0
`define UTQ_ERR_PARITY 2
`define UTQ_ERR_FRAMING 1
`define UTQ_ERR_OVERRUN 0

// ****************************************
// Parity types
// ****************************************
`define UTQ_PAR_NONE 2'h0
`define UTQ_PAR_ZERO 2'h1
`define UTQ_PAR_ODD 2'h2
`define UTQ_PAR_EVEN 2'h3

// ****************************************
// Timing
// ****************************************
`define UTQ_CLK_HZ 10000000
`define UTQ_BAUD_RESET 16'h0056
`define UTQ_BAUD_BPS 115200

`endif

// >>> core/utq_pkg.sv
// Purpose: Types for the serial transmit queue and receiver.
// Assumes: Nothing beyond the defs header.
// Notes:   Types only.
package utq_pkg;
	typedef enum logic [1:0] {
		UTQ_RX_IDLE = 2'h0,
		UTQ_RX_START = 2'h1,
		UTQ_RX_DATA = 2'h3,
		UTQ_RX_STOP = 2'h2
	} utq_rx_e;
	typedef enum logic [1:0] {
		UTQ_TX_IDLE = 2'h0,
		UTQ_TX_SHIFT = 2'h1,
		UTQ_TX_STOP = 2'h3
	} utq_tx_e;
endpackage

// >>> core/utq_receiver.sv
// Purpose: Serial receiver: start detection, shift, stop check, errors.
// Assumes: Serial line synchronous to clk; one bit is div_i+1 clocks.
// Notes:   Reports frame end as one-cycle pulses with error bits.
`timescale 1ns/1ps
`include "utq_defs.svh"
module utq_receiver
	import utq_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Configuration
	input wire logic enable_i,
	input wire logic [1:0] parity_i,
	input wire logic char8_i,
	input wire logic [15:0] div_i,
	// Line
	input wire logic rxd_i,
	// Frame result
	output logic done_o,
	output logic [7:0] data_o,
	output logic par_err_o,
	output logic frm_err_o
);
	utq_rx_e state_r;
	logic [15:0] cnt_r;
	logic [3:0] bit_r;
	logic [8:0] shift_r;
	logic tick;
	logic [3:0] nbits;
	logic has_par;
	logic par_bad;

	assign tick = (cnt_r == 16'h0000);
	assign has_par = (parity_i != `UTQ_PAR_NONE);
	assign nbits = (char8_i ? 4'h8 : 4'h7) + {3'h0, has_par};
	always_comb begin
		par_bad = 1'b0;
		if (parity_i == `UTQ_PAR_EVEN) begin
			par_bad = ^shift_r;
		end else if (parity_i == `UTQ_PAR_ODD) begin
			par_bad = ~(^shift_r);
		end
	end

	// ****************************************
	// Frame sequencer
	// ****************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= UTQ_RX_IDLE;
			cnt_r <= 16'h0000;
			bit_r <= 4'h0;
			shift_r <= 9'h000;
			done_o <= 1'b0;
			data_o <= 8'h00;
			par_err_o <= 1'b0;
			frm_err_o <= 1'b0;
		end else begin
			done_o <= 1'b0;
			if (!enable_i) begin
				state_r <= UTQ_RX_IDLE;
			end else begin
				case (state_r)
					UTQ_RX_IDLE: begin
						if (!rxd_i) begin
							state_r <= UTQ_RX_START;
							cnt_r <= {1'b0, div_i[15:1]};
						end
					end
					UTQ_RX_START: begin
						if (tick) begin
							cnt_r <= div_i;
							bit_r <= 4'h0;
							shift_r <= 9'h000;
							state_r <= rxd_i ? UTQ_RX_IDLE : UTQ_RX_DATA;
						end else begin
							cnt_r <= cnt_r - 16'h0001;
						end
					end
					UTQ_RX_DATA: begin
						if (tick) begin
							cnt_r <= div_i;
							shift_r[bit_r] <= rxd_i;
							bit_r <= bit_r + 4'h1;
							if (bit_r == nbits - 4'h1) begin
								state_r <= UTQ_RX_STOP;
							end
						end else begin
							cnt_r <= cnt_r - 16'h0001;
						end
					end
					UTQ_RX_STOP: begin
						if (tick) begin
							state_r <= UTQ_RX_IDLE;
							done_o <= 1'b1;
							data_o <= char8_i ? shift_r[7:0]
								: {1'b0, shift_r[6:0]};
							par_err_o <= has_par && par_bad;
							frm_err_o <= !rxd_i;
						end else begin
							cnt_r <= cnt_r - 16'h0001;
						end
					end
					default: state_r <= UTQ_RX_IDLE;
				endcase
			end
		end
	end
endmodule

// >>> testbench/utq_remote.sv
// Purpose: Remote serial transceiver model on the line.
// Assumes: bit_clks clocks per bit; nchar bits per collected character, 8 per sent one.
// Notes:   Sends frames on rxd, collects bytes seen on txd.
`timescale 1ns/1ps
`include "utq_defs.svh"
module utq_remote (
	// Clock
	input wire logic clk,
	// Line
	input wire logic txd,
	output logic rxd
);
	int bit_clks = 8;
	int nchar = 8;
	logic ok;
	logic [1:0] par_mode = `UTQ_PAR_NONE;
	logic [7:0] got_q[$];
	logic [7:0] sh;
	initial rxd = 1'b1;
	task automatic put(input logic b);
		rxd <= b;
		repeat (bit_clks) @(posedge clk);
	endtask
	// ****
	// Frame sender, optional bad parity or bad stop bit
	// ****
	task automatic send(input logic [7:0] d, input logic bp, input logic bs);
		put(1'b0);
		for (int i = 0; i < 8; i++) put(d[i]);
		if (par_mode == `UTQ_PAR_ZERO) put(bp);
		else if (par_mode != `UTQ_PAR_NONE)
			put(((par_mode == `UTQ_PAR_ODD) ? ~^d : ^d) ^ bp);
		put(~bs);
		rxd <= 1'b1;
	endtask
	always begin
		@(negedge txd);
		sh = 8'h00;
		ok = 1'b1;
		repeat (bit_clks / 2) @(posedge clk);
		for (int i = 0; i < nchar; i++) begin
			repeat (bit_clks) @(posedge clk);
			sh[i] = txd;
		end
		if (par_mode != `UTQ_PAR_NONE) begin
			repeat (bit_clks) @(posedge clk);
			if (par_mode == `UTQ_PAR_EVEN) ok = (txd === ^sh);
			else if (par_mode == `UTQ_PAR_ODD) ok = (txd === ~^sh);
			else ok = (txd === 1'b0);
		end
		repeat (bit_clks) @(posedge clk);
		if (ok && txd === 1'b1) got_q.push_back(sh);
	end
endmodule

// >>> testbench/utq_top_chk.sv
// Purpose: Port-level assertions for the serial queue block.
// Assumes: Mode register tracked from full-word AXI writes.
// Notes:   Bound into utq_top at the foot of this file.
`timescale 1ns/1ps
`include "utq_defs.svh"
module utq_top_chk (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST_N,
	// AXI4-Lite
	input wire logic [4:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	input wire logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic S_AXI_WVALID,
	input wire logic S_AXI_WREADY,
	input wire logic S_AXI_BVALID,
	input wire logic S_AXI_ARVALID,
	input wire logic S_AXI_ARREADY,
	input wire logic S_AXI_RVALID,
	// Line and interrupts
	input wire logic SERIAL_TRANSMIT_PIN,
	input wire logic RX_COMPLETE_IRQ,
	input wire logic RX_ERROR_IRQ,
	input wire logic TX_COMPLETE_IRQ
);
	logic [4:0] aw_r;
	logic [7:0] wd_r;
	logic [7:0] mode_r;
	logic bv_r;
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (!RST_N);
	// ****
	// Mode shadow
	// ****
	always_ff @(posedge CORE_CLK or negedge RST_N) begin
		if (!RST_N) begin
			aw_r <= 5'h00;
			wd_r <= 8'h00;
			bv_r <= 1'b0;
			mode_r <= `UTQ_MODE_RESET;
		end else begin
			if (S_AXI_AWVALID && S_AXI_AWREADY) aw_r <= S_AXI_AWADDR;
			if (S_AXI_WVALID && S_AXI_WREADY) wd_r <= S_AXI_WDATA[7:0];
			bv_r <= S_AXI_BVALID;
			if (S_AXI_BVALID && !bv_r && aw_r == `UTQ_OFS_MODE)
				mode_r <= wd_r;
		end
	end
	// ****
	// Assertions
	// ****
	rst_idle_a: assert property ($rose(RST_N) |->
		SERIAL_TRANSMIT_PIN && !S_AXI_BVALID && !TX_COMPLETE_IRQ)
		else $error("outputs not idle after reset");
	rx_quiet_a: assert property (!(mode_r[7] && mode_r[5]) |->
		!RX_COMPLETE_IRQ && !RX_ERROR_IRQ)
		else $error("receive interrupt while disabled");
	irq_excl_a: assert property (!(RX_COMPLETE_IRQ && RX_ERROR_IRQ))
		else $error("both receive interrupts at once");
	route_err_a: assert property (RX_ERROR_IRQ |-> !mode_r[0])
		else $error("error interrupt with routing bit set");
	tx_stop_a: assert property (TX_COMPLETE_IRQ |-> SERIAL_TRANSMIT_PIN
		##1 SERIAL_TRANSMIT_PIN && !TX_COMPLETE_IRQ)
		else $error("transmit interrupt outside stop bit");
	tx_idle_a: assert property (!(mode_r[7] && mode_r[6]) |->
		SERIAL_TRANSMIT_PIN && !TX_COMPLETE_IRQ)
		else $error("transmitter active while disabled");
	rx_pulse_a: assert property (RX_COMPLETE_IRQ |=>
		!RX_COMPLETE_IRQ [*8])
		else $error("completion pulse too long");
	wr_resp_a: assert property (S_AXI_AWVALID && S_AXI_AWREADY |->
		##[1:4] S_AXI_BVALID)
		else $error("write response missing");
	rd_resp_a: assert property (S_AXI_ARVALID && S_AXI_ARREADY |=>
		S_AXI_RVALID)
		else $error("read data late");
	rx_err_c: cover property (RX_ERROR_IRQ);
	rx_done_c: cover property (RX_COMPLETE_IRQ);
	tx_done_c: cover property (TX_COMPLETE_IRQ);
endmodule
bind utq_top utq_top_chk utq_top_chk_i (.CORE_CLK, .RST_N, .S_AXI_AWADDR,
	.S_AXI_AWVALID, .S_AXI_AWREADY, .S_AXI_WDATA, .S_AXI_WVALID,
	.S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY,
	.S_AXI_RVALID, .SERIAL_TRANSMIT_PIN, .RX_COMPLETE_IRQ, .RX_ERROR_IRQ,
	.TX_COMPLETE_IRQ);

// >>> testbench/tb.sv
// Purpose: Self-checking bench for the serial queue block.
// Assumes: Eight clocks per bit after the divisor write.
// Notes:   Random data from a fixed seed.
`timescale 1ns/1ps
`include "utq_defs.svh"
module tb;
	localparam int BIT = 8;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [4:0] awa = 5'h00;
	logic [4:0] ara = 5'h00;
	logic [31:0] wd = 32'h0;
	logic awv = 1'b0;
	logic wv = 1'b0;
	logic arv = 1'b0;
	logic awr, wrd, bv, arr, rv, rxd, txd, irc, ire, itx;
	logic [1:0] rresp;
	logic [1:0] bresp;
	logic [31:0] rdat;
	int fails = 0;
	int comparisons = 0;
	int n_rc = 0;
	int n_re = 0;
	int n_tx = 0;
	always #50 clk = ~clk;
	utq_top utq_top_i (.CORE_CLK(clk), .RST_N(rst_n), .S_AXI_AWADDR(awa),
		.S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_WDATA(wd),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wv), .S_AXI_WREADY(wrd),
		.S_AXI_BRESP(bresp), .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
		.S_AXI_RDATA(rdat), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rv),
		.S_AXI_RREADY(1'b1), .SERIAL_RECEIVE_PIN(rxd),
		.SERIAL_TRANSMIT_PIN(txd), .RX_COMPLETE_IRQ(irc),
		.RX_ERROR_IRQ(ire), .TX_COMPLETE_IRQ(itx));
	utq_remote utq_remote_i (.clk(clk), .txd(txd), .rxd(rxd));
	always @(posedge clk) begin
		n_rc <= n_rc + int'(irc === 1'b1);
		n_re <= n_re + int'(ire === 1'b1);
		n_tx <= n_tx + int'(itx === 1'b1);
	end
	// ****
	// Tasks and functions
	// ****
	function automatic logic par_chk(input logic [1:0] pm);
		return pm == `UTQ_PAR_ODD || pm == `UTQ_PAR_EVEN;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		comparisons++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t got %h expected %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		do begin
			@(posedge clk);
			if (awr === 1'b1) awv <= 1'b0;
			if (wrd === 1'b1) wv <= 1'b0;
		end while (bv !== 1'b1);
	endtask
	task automatic rd(input logic [4:0] a, output logic [31:0] d,
		output logic [1:0] r);
		ara <= a;
		arv <= 1'b1;
		do begin
			@(posedge clk);
			if (arr === 1'b1) arv <= 1'b0;
		end while (rv !== 1'b1);
		d = rdat;
		r = rresp;
	endtask
	task automatic rchk(input logic [4:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0] r;
		rd(a, d, r);
		chk(d, e);
	endtask
	task automatic frame(input logic [7:0] d, input logic bp, input logic bs,
		input int erc, input int ere, input logic [31:0] eerr);
		int c0;
		int e0;
		c0 = n_rc;
		e0 = n_re;
		utq_remote_i.send(d, bp, bs);
		repeat (2) @(posedge clk);
		chk(n_rc - c0, erc);
		chk(n_re - e0, ere);
		rchk(`UTQ_OFS_ERR, eerr);
	endtask
	task automatic finish_test;
		$display("comparisons %0d fails %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		#3000000;
		fails++;
		finish_test();
	end
	// ****
	// Main sequence
	// ****
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		logic [1:0] pm;
		logic [7:0] b0;
		logic [7:0] b1;
		logic p;
		void'($urandom(32'h9F8E52B9));
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		rchk(`UTQ_OFS_MODE, 32'(`UTQ_MODE_RESET));
		rchk(`UTQ_OFS_BAUD, 32'(`UTQ_BAUD_RESET));
		rd(5'h18, d, r);
		chk(r, 2'h2);
		wr(5'h18, 32'h0);
		chk(32'(bresp), 32'h2);
		wr(`UTQ_OFS_BAUD, 32'(BIT - 1));
		chk(32'(bresp), 32'h0);
		utq_remote_i.bit_clks = BIT;
		wr(`UTQ_OFS_MODE, 32'hC4);
		rchk(`UTQ_OFS_TXFLAG, 32'h0);
		b0 = 8'($urandom);
		b1 = 8'($urandom);
		wr(`UTQ_OFS_TXBUF, {24'h0, b0});
		do rd(`UTQ_OFS_TXFLAG, d, r); while (d[1] !== 1'b0);
		chk(d, 32'h1);
		wr(`UTQ_OFS_TXBUF, {24'h0, b1});
		rchk(`UTQ_OFS_TXFLAG, 32'h3);
		while (n_tx < 1) @(posedge clk);
		do rd(`UTQ_OFS_TXFLAG, d, r); while (d[1] !== 1'b0);
		chk(d, 32'h1);
		while (n_tx < 2) @(posedge clk);
		rchk(`UTQ_OFS_TXFLAG, 32'h0);
		repeat (BIT) @(posedge clk);
		chk(utq_remote_i.got_q.size(), 2);
		chk(utq_remote_i.got_q[0], b0);
		chk(utq_remote_i.got_q[1], b1);
		wr(`UTQ_OFS_MODE, 32'h80);
		rchk(`UTQ_OFS_TXFLAG, 32'h0);
		for (int k = 0; k < 4; k++) begin
			pm = 2'(k);
			p = par_chk(pm);
			utq_remote_i.par_mode = pm;
			wr(`UTQ_OFS_MODE, {24'h0, 3'b101, pm, 3'b100});
			b0 = 8'($urandom);
			frame(b0, 1'b0, 1'b0, 1, 0, 32'h0);
			rchk(`UTQ_OFS_RXBUF, {24'h0, b0});
			frame(8'($urandom), 1'b1, 1'b0, !p, p, {29'h0, p, 2'h0});
			rd(`UTQ_OFS_RXBUF, d, r);
			rchk(`UTQ_OFS_ERR, 32'h0);
		end
		frame(8'($urandom), 1'b0, 1'b1, 0, 1, 32'h2);
		rd(`UTQ_OFS_RXBUF, d, r);
		b0 = 8'($urandom);
		frame(b0, 1'b0, 1'b0, 1, 0, 32'h0);
		frame(8'($urandom), 1'b0, 1'b0, 0, 1, 32'h1);
		rchk(`UTQ_OFS_RXBUF, {24'h0, b0});
		wr(`UTQ_OFS_MODE, 32'hBD);
		frame(8'($urandom), 1'b1, 1'b0, 1, 0, 32'h4);
		rd(`UTQ_OFS_RXBUF, d, r);
		frame(b0, 1'b0, 1'b0, 1, 0, 32'h0);
		rchk(`UTQ_OFS_RXBUF, {24'h0, b0});
		fork
			frame(8'($urandom), 1'b1, 1'b1, 0, 0, 32'h0);
			begin
				repeat (3 * BIT) @(posedge clk);
				wr(`UTQ_OFS_MODE, 32'h80);
			end
		join
		frame(8'($urandom), 1'b0, 1'b0, 0, 0, 32'h0);
		rchk(`UTQ_OFS_RXBUF, {24'h0, b0});
		utq_remote_i.nchar = 7;
		utq_remote_i.par_mode = `UTQ_PAR_EVEN;
		wr(`UTQ_OFS_MODE, 32'hDA);
		b1 = 8'($urandom);
		wr(`UTQ_OFS_TXBUF, {24'h0, b1});
		while (n_tx < 3) @(posedge clk);
		rchk(`UTQ_OFS_TXFLAG, 32'h0);
		repeat (BIT) @(posedge clk);
		chk(utq_remote_i.got_q.size(), 3);
		chk(utq_remote_i.got_q[2], {25'h0, b1[6:0]});
		finish_test();
	end
endmodule
